// file: hw/hlt_pkg.sv
// constants, types and helpers for the hardware limit timer mode controller
package hlt_pkg;

  // register byte addresses
  localparam int          ADR_W      = 8;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_MODE   = 8'h04;
  localparam logic [7:0]  REG_PERIOD = 8'h08;
  localparam logic [7:0]  REG_CMP    = 8'h0c;
  localparam logic [7:0]  REG_COUNT  = 8'h10;
  localparam logic [7:0]  REG_STAT   = 8'h14;

  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int STAT_PWM_BIT = 0;
  localparam int STAT_ACT_BIT = 1;
  localparam int STAT_HLD_BIT = 2;
  localparam int STAT_ERS_BIT = 3;

  // reset values
  localparam logic [7:0] PERIOD_RST = 8'hff;
  localparam logic [7:0] CMP_RST    = 8'h00;
  localparam logic [7:0] COUNT_RST  = 8'h00;
  localparam logic [4:0] MODE_RST   = 5'h00;

  // timer clocks from a reset edge or level change to the counter's reaction
  localparam int         RST_DLY_CLKS = 2;
  localparam logic [1:0] DLY_LAST     = 2'(RST_DLY_CLKS - 1);

  // operating modes
  localparam logic [4:0] M_SW_GATE  = 5'h00;
  localparam logic [4:0] M_GATE_HI  = 5'h01;
  localparam logic [4:0] M_GATE_LO  = 5'h02;
  localparam logic [4:0] M_ER_ANY   = 5'h03;
  localparam logic [4:0] M_ER_RISE  = 5'h04;
  localparam logic [4:0] M_ER_FALL  = 5'h05;
  localparam logic [4:0] M_LR_LOW   = 5'h06;
  localparam logic [4:0] M_LR_HIGH  = 5'h07;
  localparam logic [4:0] M_OS_SW    = 5'h08;
  localparam logic [4:0] M_OS_RISE  = 5'h09;
  localparam logic [4:0] M_OS_FALL  = 5'h0a;
  localparam logic [4:0] M_OS_ANY   = 5'h0b;
  localparam logic [4:0] M_OSR_RISE = 5'h0c;
  localparam logic [4:0] M_OSR_FALL = 5'h0d;
  localparam logic [4:0] M_OSL_LOW  = 5'h0e;
  localparam logic [4:0] M_OSL_HIGH = 5'h0f;

  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HOLD} hlt_state_type;

  // per-tick actions decided by the mode logic
  typedef struct packed {
    logic adv;
    logic clr;
    logic stop;
    logic pset;
    logic dly_inc;
  } hlt_act_type;

  // edge picked by a mode: rising, falling or either
  function automatic logic hlt_edge(input logic want_rise, input logic want_fall,
                                    input logic rise, input logic fall);
    hlt_edge = (want_rise & rise) | (want_fall & fall);
  endfunction

endpackage

// file: hw/hlt_timer.sv
// hardware limit timer mode controller with pwm drive and wishbone registers
//
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module hlt_timer #(
  parameter int TICK_DIV = 1
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // external reset / trigger
  input  wire logic        ext_reset_input_i,
  // time base toward the compare/pwm consumer
  output logic      [7:0]  timer_count_o,
  output logic             pwm_drive_o,
  output logic             period_match_o,
  output logic             run_o
);

  logic [4:0]               mode;
  logic [7:0]               period_value;
  logic [7:0]               pulse_width_compare;
  logic [7:0]               timer_count;
  logic                     run;
  logic                     pwm;
  hlt_pkg::hlt_state_type   state;
  hlt_pkg::hlt_state_type   next_state;
  hlt_pkg::hlt_act_type     act;
  logic [1:0]               dly;
  logic                     ers_meta;
  logic                     ers_sync;
  logic                     ers_prev;
  logic                     rise;
  logic                     fall;
  logic                     match;
  logic                     dly_end;
  logic                     lvl_now;
  logic                     lvl_prev;
  logic                     tick;
  logic [15:0]              div_cnt;
  logic                     req;
  logic                     wr;

  // timer clock enable; TICK_DIV of 1 gives a tick every cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || div_cnt == 16'(TICK_DIV - 1)) begin
      div_cnt <= 16'h0000;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick <= 1'b0;
    end else begin
      tick <= (div_cnt == 16'(TICK_DIV - 1));
    end
  end

  // two-stage synchroniser; only the second stage feeds detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ers_meta <= 1'b0;
      ers_sync <= 1'b0;
    end else begin
      ers_meta <= ext_reset_input_i;
      ers_sync <= ers_meta;
    end
  end

  // previous level sampled per timer clock so edges are counted in ticks
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ers_prev <= 1'b0;
    end else if (tick) begin
      ers_prev <= ers_sync;
    end
  end

  assign rise    = ers_sync & ~ers_prev;
  assign fall    = ~ers_sync & ers_prev;
  // a period of zero pins the count at zero in the gated modes
  assign match   = (timer_count == period_value);
  assign dly_end = (dly == hlt_pkg::DLY_LAST);
  // reset level active: low for the low-level modes, high otherwise
  assign lvl_now  = (mode == hlt_pkg::M_LR_LOW || mode == hlt_pkg::M_OSL_LOW) ?
                    ~ers_sync : ers_sync;
  assign lvl_prev = (mode == hlt_pkg::M_LR_LOW || mode == hlt_pkg::M_OSL_LOW) ?
                    ~ers_prev : ers_prev;

  // mode decode: what the counter, run bit and pwm do on this tick
  always_comb begin
    act        = '0;
    next_state = state;
    if (!run) begin
      // a paused software one-shot remembers that its cycle is in progress
      if (mode != hlt_pkg::M_OS_SW) begin
        next_state = hlt_pkg::ST_IDLE;
      end
    end else begin
      case (mode)
        hlt_pkg::M_SW_GATE, hlt_pkg::M_GATE_HI, hlt_pkg::M_GATE_LO: begin
          if (mode == hlt_pkg::M_SW_GATE ||
              (mode == hlt_pkg::M_GATE_HI && ers_sync) ||
              (mode == hlt_pkg::M_GATE_LO && !ers_sync)) begin
            if (match) begin
              act.clr  = 1'b1;
              act.pset = 1'b1;
            end else begin
              act.adv = 1'b1;
            end
          end
        end
        hlt_pkg::M_ER_ANY, hlt_pkg::M_ER_RISE, hlt_pkg::M_ER_FALL: begin
          if (hlt_pkg::hlt_edge(mode != hlt_pkg::M_ER_FALL, mode != hlt_pkg::M_ER_RISE,
                       rise, fall)) begin
            act.clr    = 1'b1;
            next_state = hlt_pkg::ST_HOLD;
          end else if (state == hlt_pkg::ST_HOLD) begin
            if (dly_end) begin
              act.adv    = 1'b1;
              act.pset   = 1'b1;
              next_state = hlt_pkg::ST_RUN;
            end else begin
              act.clr     = 1'b1;
              act.dly_inc = 1'b1;
            end
          end else if (match) begin
            act.clr    = 1'b1;
            act.pset   = 1'b1;
            next_state = hlt_pkg::ST_RUN;
          end else begin
            act.adv    = 1'b1;
            next_state = hlt_pkg::ST_RUN;
          end
        end
        hlt_pkg::M_LR_LOW, hlt_pkg::M_LR_HIGH: begin
          if (state != hlt_pkg::ST_HOLD) begin
            if (lvl_now && dly_end) begin
              act.clr    = 1'b1;
              next_state = hlt_pkg::ST_HOLD;
            end else begin
              act.dly_inc = lvl_now;
              if (match) begin
                act.clr  = 1'b1;
                act.pset = 1'b1;
              end else begin
                act.adv = 1'b1;
              end
            end
          end else begin
            act.clr = 1'b1;
            if (!lvl_now && dly_end) begin
              act.clr    = 1'b0;
              act.adv    = 1'b1;
              act.pset   = 1'b1;
              next_state = hlt_pkg::ST_RUN;
            end else begin
              act.dly_inc = !lvl_now;
            end
          end
        end
        hlt_pkg::M_OS_SW: begin
          if (state == hlt_pkg::ST_IDLE) begin
            act.pset = 1'b1;
          end
          next_state = hlt_pkg::ST_RUN;
          if (match) begin
            act.clr    = 1'b1;
            act.stop   = 1'b1;
            next_state = hlt_pkg::ST_IDLE;
          end else begin
            act.adv = 1'b1;
          end
        end
        hlt_pkg::M_OS_RISE, hlt_pkg::M_OS_FALL, hlt_pkg::M_OS_ANY: begin
          if (state == hlt_pkg::ST_IDLE) begin
            if (hlt_pkg::hlt_edge(mode != hlt_pkg::M_OS_FALL, mode != hlt_pkg::M_OS_RISE,
                         rise, fall)) begin
              act.pset   = 1'b1;
              next_state = hlt_pkg::ST_RUN;
            end
          end else if (match) begin
            act.clr    = 1'b1;
            act.stop   = 1'b1;
            next_state = hlt_pkg::ST_IDLE;
          end else begin
            act.adv = 1'b1;
          end
        end
        hlt_pkg::M_OSR_RISE, hlt_pkg::M_OSR_FALL: begin
          if (hlt_pkg::hlt_edge(mode == hlt_pkg::M_OSR_RISE, mode == hlt_pkg::M_OSR_FALL,
                       rise, fall)) begin
            act.pset = 1'b1;
            if (state == hlt_pkg::ST_IDLE) begin
              next_state = hlt_pkg::ST_RUN;
            end else begin
              act.clr    = 1'b1;
              next_state = hlt_pkg::ST_HOLD;
            end
          end else if (state == hlt_pkg::ST_HOLD) begin
            if (dly_end) begin
              act.adv    = 1'b1;
              next_state = hlt_pkg::ST_RUN;
            end else begin
              act.clr     = 1'b1;
              act.dly_inc = 1'b1;
            end
          end else if (state == hlt_pkg::ST_RUN) begin
            if (match) begin
              act.clr    = 1'b1;
              act.stop   = 1'b1;
              next_state = hlt_pkg::ST_IDLE;
            end else begin
              act.adv = 1'b1;
            end
          end
        end
        hlt_pkg::M_OSL_LOW, hlt_pkg::M_OSL_HIGH: begin
          if (lvl_now) begin
            act.clr = 1'b1;
          end else if (state == hlt_pkg::ST_IDLE) begin
            if (lvl_prev) begin
              act.pset   = 1'b1;
              next_state = hlt_pkg::ST_RUN;
            end
          end else if (match) begin
            act.clr    = 1'b1;
            act.stop   = 1'b1;
            next_state = hlt_pkg::ST_IDLE;
          end else begin
            act.adv = 1'b1;
          end
        end
        // reserved modes freeze the count while run stays set
        default: begin
          act = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= hlt_pkg::ST_IDLE;
    end else if (tick) begin
      // state moves on timer clocks only, so every delay counts in ticks
      state <= next_state;
    end
  end

  // delay counter restarts whenever the mode logic stops asking for it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly <= 2'h0;
    end else if (tick) begin
      if (act.dly_inc && !dly_end) begin
        dly <= dly + 2'h1;
      end else begin
        dly <= 2'h0;
      end
    end
  end

  // wishbone: one wait state, ack for one cycle, unmapped reads give zero
  // masking with ack keeps a strobe held into the ack cycle from being taken twice
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      case (wb_adr_i)
        hlt_pkg::REG_CTRL:   wb_dat_o <= 32'(run);
        hlt_pkg::REG_MODE:   wb_dat_o <= 32'(mode);
        hlt_pkg::REG_PERIOD: wb_dat_o <= 32'(period_value);
        hlt_pkg::REG_CMP:    wb_dat_o <= 32'(pulse_width_compare);
        hlt_pkg::REG_COUNT:  wb_dat_o <= 32'(timer_count);
        hlt_pkg::REG_STAT: begin
          wb_dat_o                        <= 32'h0000_0000;
          wb_dat_o[hlt_pkg::STAT_PWM_BIT] <= pwm;
          wb_dat_o[hlt_pkg::STAT_ACT_BIT] <= (state != hlt_pkg::ST_IDLE);
          wb_dat_o[hlt_pkg::STAT_HLD_BIT] <= (state == hlt_pkg::ST_HOLD);
          wb_dat_o[hlt_pkg::STAT_ERS_BIT] <= ers_sync;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode                <= hlt_pkg::MODE_RST;
      period_value        <= hlt_pkg::PERIOD_RST;
      pulse_width_compare <= hlt_pkg::CMP_RST;
    end else if (wr) begin
      if (wb_adr_i == hlt_pkg::REG_MODE) begin
        mode <= wb_dat_i[4:0];
      end
      if (wb_adr_i == hlt_pkg::REG_PERIOD) begin
        period_value <= wb_dat_i[7:0];
      end
      if (wb_adr_i == hlt_pkg::REG_CMP) begin
        pulse_width_compare <= wb_dat_i[7:0];
      end
    end
  end

  // software write of one beats a hardware clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run <= 1'b0;
    end else if (wr && wb_adr_i == hlt_pkg::REG_CTRL) begin
      run <= wb_dat_i[hlt_pkg::CTRL_RUN_BIT];
    end else if (tick && act.stop) begin
      run <= 1'b0;
    end
  end

  // a software write to the count overrides the tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_count <= hlt_pkg::COUNT_RST;
    end else if (wr && wb_adr_i == hlt_pkg::REG_COUNT) begin
      timer_count <= wb_dat_i[7:0];
    end else if (tick && act.clr) begin
      timer_count <= hlt_pkg::COUNT_RST;
    end else if (tick && act.adv) begin
      timer_count <= timer_count + 8'h01;
    end
  end

  // drive ends only while counting, so a held count keeps the pulse high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwm <= 1'b0;
    end else if (tick && act.pset) begin
      pwm <= 1'b1;
    end else if (tick && act.adv && timer_count == pulse_width_compare) begin
      pwm <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_match_o <= 1'b0;
    end else begin
      // only a zeroing with the count at the period flags a match
      period_match_o <= tick & act.clr & match;
    end
  end

  assign timer_count_o = timer_count;
  assign pwm_drive_o   = pwm;
  assign run_o         = run;

endmodule

// file: tb/hlt_ers_src.sv
// behavioural source of the external reset / trigger line
`timescale 1ns/1ps
module hlt_ers_src (
  // clock
  input  wire logic       clk_i,
  // requested level and lag in clocks
  input  wire logic       level_i,
  input  wire logic [3:0] lag_i,
  // line toward the timer
  output logic            ext_reset_input_o
);
  logic [15:0] hist = 16'h0000;

  always @(posedge clk_i) begin
    hist <= {hist[14:0], level_i};
  end

  // a large lag models a slow source; the line only moves after a clock edge
  assign ext_reset_input_o = hist[lag_i];
endmodule

// file: tb/hlt_timer_monitor.sv
// port-level checks for the hardware limit timer
`timescale 1ns/1ps
module hlt_timer_monitor #(
  parameter int TICK_DIV = 1
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_i,
  // wishbone slave
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // trigger and time base
  input wire logic        ext_reset_input_i,
  input wire logic [7:0]  timer_count_o,
  input wire logic        pwm_drive_o,
  input wire logic        period_match_o,
  input wire logic        run_o
);
  logic req;
  logic wreq;

  assign req  = wb_cyc_i & wb_stb_i;
  assign wreq = req & wb_we_i;

  default clocking mon_cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(req))
    else $error("ack without request");
  a_read_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  a_count_step_legal: assert property (!wreq |=> timer_count_o == $past(timer_count_o)
    || timer_count_o == $past(timer_count_o) + 8'h01 || timer_count_o == 8'h00)
    else $error("count moved by an illegal step");
  a_match_zero_count: assert property (period_match_o |-> timer_count_o == 8'h00)
    else $error("period match with nonzero count");
  a_idle_count_held: assert property (!run_o && !wreq |=> $stable(timer_count_o))
    else $error("count moved while run bit clear");
  a_run_set_sw: assert property ($rose(run_o) |-> $past(wreq))
    else $error("run bit set without a write");
  a_run_clear_cause: assert property ($fell(run_o) |-> period_match_o || $past(wreq))
    else $error("run bit cleared without match or write");

  cover property ($fell(run_o) && period_match_o);
  cover property (period_match_o && run_o);
  cover property ($rose(pwm_drive_o));
endmodule

bind hlt_timer hlt_timer_monitor #(.TICK_DIV(TICK_DIV)) hlt_timer_monitor_inst (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_input_i(ext_reset_input_i),
  .timer_count_o(timer_count_o), .pwm_drive_o(pwm_drive_o),
  .period_match_o(period_match_o), .run_o(run_o));

// file: tb/hlt_timer_tb.sv
// self-checking bench for the hardware limit timer
`timescale 1ns/1ps
module hlt_timer_tb;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        ers_line;
  logic [7:0]  timer_count_o;
  logic        pwm_drive_o;
  logic        period_match_o;
  logic        run_o;
  logic        ers_lvl;
  logic [3:0]  ers_lag;
  logic [31:0] rdat;
  logic        pwm_seen;
  logic        l0;
  logic [7:0]  c_hold;
  int          i;
  int          n_errors;
  int          samples_checked;

  hlt_timer #(.TICK_DIV(1)) hlt_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_reset_input_i(ers_line),
    .timer_count_o(timer_count_o), .pwm_drive_o(pwm_drive_o),
    .period_match_o(period_match_o), .run_o(run_o));

  hlt_ers_src hlt_ers_src_inst (
    .clk_i(clk_i), .level_i(ers_lvl), .lag_i(ers_lag), .ext_reset_input_o(ers_line));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, {24'h000000, d});
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rdat, {24'h000000, e});
  endtask

  // level changes land on a rising edge, checks look at settled values
  task automatic ers(input logic v);
    @(posedge clk_i);
    ers_lvl <= v;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // waits for the hardware to end a one-shot cycle, noting any pwm drive
  task automatic wait_idle();
    int n;
    n = 0;
    pwm_seen = 1'b0;
    while (run_o !== 1'b0 && n < 300) begin
      @(negedge clk_i);
      pwm_seen = pwm_seen | pwm_drive_o;
      n++;
    end
    if (run_o !== 1'b0) begin
      n_errors++;
      stop_test();
    end
  endtask

  initial begin
    rst_i    = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i  = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h00000000;
    ers_lvl  = 1'b0;
    ers_lag  = 4'h0;
    n_errors = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(hlt_pkg::REG_PERIOD, 8'hff);
    rd(hlt_pkg::REG_CMP, 8'h00);
    rd(hlt_pkg::REG_MODE, 8'h00);
    rd(hlt_pkg::REG_COUNT, 8'h00);
    rd(8'h1c, 8'h00);
    rd(hlt_pkg::REG_STAT, 8'h00);
    wb_sel_i <= 4'h0;
    wr(hlt_pkg::REG_CMP, 8'h55);
    wb_sel_i <= 4'h1;
    rd(hlt_pkg::REG_CMP, 8'h00);
    $display("test reset_values done");
    wr(hlt_pkg::REG_PERIOD, 8'h08);
    wr(hlt_pkg::REG_CMP, 8'h04);
    wr(hlt_pkg::REG_MODE, {3'h0, hlt_pkg::M_OS_SW});
    wr(hlt_pkg::REG_CTRL, 8'h01);
    wait_idle();
    check(pwm_seen, 1'b1);
    check(timer_count_o, 8'h00);
    check(pwm_drive_o, 1'b0);
    rd(hlt_pkg::REG_CTRL, 8'h00);
    wr(hlt_pkg::REG_CTRL, 8'h01);
    wr(hlt_pkg::REG_CTRL, 8'h00);
    settle(0);
    c_hold = timer_count_o;
    settle(6);
    check(timer_count_o, c_hold);
    check(pwm_drive_o, 1'b1);
    rd(hlt_pkg::REG_STAT, 8'h03);
    wr(hlt_pkg::REG_CTRL, 8'h01);
    wait_idle();
    check(timer_count_o, 8'h00);
    $display("test software_one_shot done");
    wr(hlt_pkg::REG_PERIOD, 8'h05);
    wr(hlt_pkg::REG_MODE, {3'h0, hlt_pkg::M_SW_GATE});
    wr(hlt_pkg::REG_CTRL, 8'h01);
    c_hold = 8'h00;
    for (i = 1; i <= 20; i++) begin
      @(negedge clk_i);
      c_hold = c_hold + 8'(period_match_o);
      check(timer_count_o, 8'(i % 6));
    end
    check(c_hold, 8'h03);
    wr(hlt_pkg::REG_CTRL, 8'h00);
    $display("test period_wrap done");
    wr(hlt_pkg::REG_PERIOD, 8'hff);
    for (i = 0; i < 2; i++) begin
      ers(i[0]);
      wr(hlt_pkg::REG_COUNT, 8'h00);
      wr(hlt_pkg::REG_MODE, hlt_pkg::M_GATE_HI + 8'(i));
      wr(hlt_pkg::REG_CTRL, 8'h01);
      settle(8);
      check(timer_count_o, 8'h00);
      ers(!i[0]);
      settle(8);
      check(timer_count_o != 8'h00, 1'b1);
      ers(i[0]);
      settle(4);
      c_hold = timer_count_o;
      settle(4);
      check(timer_count_o, c_hold);
      wr(hlt_pkg::REG_CTRL, 8'h00);
    end
    $display("test gate done");
    for (i = 0; i < 3; i++) begin
      ers(1'b0);
      wr(hlt_pkg::REG_COUNT, 8'h00);
      wr(hlt_pkg::REG_MODE, hlt_pkg::M_ER_ANY + 8'(i));
      wr(hlt_pkg::REG_CTRL, 8'h01);
      settle(20);
      ers(1'b1);
      settle(6);
      check(timer_count_o < 8'h08, i != 2);
      check(pwm_drive_o, i != 2);
      settle(20);
      ers(1'b0);
      settle(6);
      check(timer_count_o < 8'h08, i != 1);
      wr(hlt_pkg::REG_CTRL, 8'h00);
    end
    $display("test edge_limit done");
    for (i = 0; i < 2; i++) begin
      wr(hlt_pkg::REG_COUNT, 8'h05);
      wr(hlt_pkg::REG_MODE, hlt_pkg::M_LR_LOW + 8'(i));
      ers(!i[0]);
      settle(4);
      ers(i[0]);
      settle(8);
      check(timer_count_o, 8'h05);
      wr(hlt_pkg::REG_CTRL, 8'h01);
      settle(8);
      check(timer_count_o, 8'h00);
      ers(!i[0]);
      settle(8);
      check(timer_count_o != 8'h00, 1'b1);
      check(pwm_drive_o, 1'b1);
      wr(hlt_pkg::REG_CTRL, 8'h00);
    end
    $display("test level_limit done");
    wr(hlt_pkg::REG_PERIOD, 8'h10);
    for (i = 0; i < 7; i++) begin
      l0 = 7'b1010010 >> i;
      ers_lag <= i[0] ? 4'h3 : 4'h0;
      ers(l0);
      settle(20);
      wr(hlt_pkg::REG_COUNT, 8'h00);
      wr(hlt_pkg::REG_MODE, hlt_pkg::M_OS_RISE + 8'(i));
      wr(hlt_pkg::REG_CTRL, 8'h01);
      settle(8);
      check(timer_count_o, 8'h00);
      ers(!l0);
      wait_idle();
      check(pwm_seen, 1'b1);
      check(timer_count_o, 8'h00);
      check(pwm_drive_o, 1'b0);
      ers(l0);
      settle(8);
      ers(!l0);
      settle(8);
      check(timer_count_o, 8'h00);
      wr(hlt_pkg::REG_CTRL, 8'h01);
      settle(8);
      check(timer_count_o, 8'h00);
      wr(hlt_pkg::REG_CTRL, 8'h00);
    end
    $display("test one_shot_edges done");
    wr(hlt_pkg::REG_PERIOD, 8'h40);
    wr(hlt_pkg::REG_MODE, {3'h0, hlt_pkg::M_OSR_RISE});
    wr(hlt_pkg::REG_CTRL, 8'h01);
    ers(1'b1);
    settle(20);
    ers(1'b0);
    settle(6);
    check(timer_count_o > 8'h08, 1'b1);
    ers(1'b1);
    settle(4);
    check(timer_count_o, 8'h00);
    check(pwm_drive_o, 1'b1);
    settle(1);
    check(timer_count_o, 8'h00);
    settle(1);
    check(timer_count_o, 8'h01);
    wait_idle();
    check(timer_count_o, 8'h00);
    $display("test limit_one_shot_reset done");
    stop_test();
  end
endmodule
